// file: hdl/abr_pkg.sv
// Constants and carrier types for the converter byte-read host port.
// Assumes a single core clock; the conversion engine itself lies outside this block.
package abr_pkg;
  localparam int RESULT_W = 12;
  localparam int BUS_W = 12;
  localparam int FIFO_DEPTH = 32;
  localparam int CLK_PERIOD_NS = 8;
  localparam int CONV_TIME_NS = 3000;
  // Shortest conversion rounds up to whole cycles
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 9;
  localparam logic [11:0] RESULT_RST = 12'h000;
  localparam logic [3:0] NIBBLE_LOW = 4'h0;
  localparam int MSB_LO = 8;
  localparam int LOW_BYTE_HI = 7;

  typedef struct packed {
    logic chipSelN;
    logic readN;
    logic highByteSelect;
  } abr_strobe_t;

  typedef struct packed {
    logic [RESULT_W-1:0] code;
  } abr_sample_t;

  typedef enum logic {
    ABR_IDLE,
    ABR_CONVERT
  } abr_state_t;
endpackage : abr_pkg

// file: hdl/abr_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
module abr_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 32
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_ff;
  logic [AW-1:0] rdPtr_ff;
  logic [AW:0] count_ff;
  logic doWrite;
  logic doRead;
  logic [AW:0] nxt_count;
  logic inReady_ff;

  assign doWrite = inValid && inReady;
  assign doRead = outValid && outReady;
  // Refusal comes from a flop so the producer never sees a combinational path
  assign inReady = inReady_ff;
  assign nxt_count = count_ff + (AW+1)'(doWrite) - (AW+1)'(doRead);
  assign outValid = (count_ff != '0);
  assign outData = mem[rdPtr_ff];

  always_ff @(posedge core_clk) begin
    if (doWrite) begin
      mem[wrPtr_ff] <= inData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      count_ff <= '0;
      inReady_ff <= 1'b1;
    end else begin
      if (doWrite) begin
        wrPtr_ff <= wrPtr_ff + 1'b1;
      end
      if (doRead) begin
        rdPtr_ff <= rdPtr_ff + 1'b1;
      end
      count_ff <= nxt_count;
      inReady_ff <= (nxt_count != (AW+1)'(DEPTH));
    end
  end
endmodule : abr_fifo

// file: hdl/abr_host_port.sv
// Device-side read/convert-start port of a 12-bit successive-approximation converter.
// Assumes strobes arrive asynchronously from the processor and pass a two-stage synchronizer;
// the analog engine hands finished codes in through a valid/ready stream.
module abr_host_port (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire abr_pkg::abr_strobe_t strobeN,
  output logic [abr_pkg::BUS_W-1:0] dataOut,
  output logic [abr_pkg::BUS_W-1:0] dataOutEn,
  output logic busyN,
  output logic sampleNow,
  input wire abr_pkg::abr_sample_t convCode,
  input wire logic convValid,
  output logic convReady
);
  abr_pkg::abr_strobe_t syncA_ff;
  abr_pkg::abr_strobe_t syncB_ff;
  abr_pkg::abr_state_t state_ff;
  logic [abr_pkg::CNT_W-1:0] convCnt_ff;
  logic [abr_pkg::RESULT_W-1:0] result_ff;
  logic readActive;
  logic readActive_ff;
  logic startReq;
  logic convDone;
  logic [abr_pkg::RESULT_W-1:0] fifoData;
  logic fifoValid;
  logic fifoPop;
  logic [abr_pkg::BUS_W-1:0] nxt_dataOut;

  // Strobes from the processor cross here; start, busy and enable lag the strobes by three clocks
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      syncA_ff <= '{chipSelN: 1'b1, readN: 1'b1, highByteSelect: 1'b0};
      syncB_ff <= '{chipSelN: 1'b1, readN: 1'b1, highByteSelect: 1'b0};
    end else begin
      syncA_ff <= strobeN;
      syncB_ff <= syncA_ff;
    end
  end

  assign readActive = !syncB_ff.chipSelN && !syncB_ff.readN;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      readActive_ff <= 1'b0;
    end else begin
      readActive_ff <= readActive;
    end
  end

  // Only the falling edge of a low-byte read asks for a conversion
  assign startReq = readActive && !readActive_ff && !syncB_ff.highByteSelect;

  // Finished codes queue here; a code arriving early waits for the timer to expire
  abr_fifo #(
    .WIDTH(abr_pkg::RESULT_W),
    .DEPTH(abr_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .inData(convCode.code),
    .inValid(convValid),
    .inReady(convReady),
    .outData(fifoData),
    .outValid(fifoValid),
    .outReady(fifoPop)
  );

  assign convDone = (state_ff == abr_pkg::ABR_CONVERT) && (convCnt_ff == '0) && fifoValid;
  assign fifoPop = convDone;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_ff <= abr_pkg::ABR_IDLE;
      convCnt_ff <= '0;
    end else begin
      unique case (state_ff)
        abr_pkg::ABR_IDLE: begin
          if (startReq) begin
            state_ff <= abr_pkg::ABR_CONVERT;
            convCnt_ff <= abr_pkg::CNT_W'(abr_pkg::CONV_CYCLES - 1);
          end
        end
        abr_pkg::ABR_CONVERT: begin
          // Further start requests are simply not looked at here
          if (convCnt_ff != '0) begin
            convCnt_ff <= convCnt_ff - 1'b1;
          end else if (convDone) begin
            state_ff <= abr_pkg::ABR_IDLE;
          end
        end
      endcase
    end
  end

  // Sampling pulse marks the effective start, after synchronization
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sampleNow <= 1'b0;
    end else begin
      sampleNow <= startReq && (state_ff == abr_pkg::ABR_IDLE);
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      busyN <= 1'b1;
    end else if (startReq && (state_ff == abr_pkg::ABR_IDLE)) begin
      busyN <= 1'b0;
    end else if (convDone) begin
      busyN <= 1'b1;
    end
  end

  // Output latch updates only at end of conversion, so a ROM-style start read sees old data
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      result_ff <= abr_pkg::RESULT_RST;
    end else if (convDone) begin
      result_ff <= fifoData;
    end
  end

  always_comb begin
    nxt_dataOut[abr_pkg::BUS_W-1:abr_pkg::MSB_LO] =
      result_ff[abr_pkg::RESULT_W-1:abr_pkg::MSB_LO];
    if (syncB_ff.highByteSelect) begin
      nxt_dataOut[abr_pkg::LOW_BYTE_HI:4] = abr_pkg::NIBBLE_LOW;
      nxt_dataOut[3:0] = result_ff[abr_pkg::RESULT_W-1:abr_pkg::MSB_LO];
    end else begin
      nxt_dataOut[abr_pkg::LOW_BYTE_HI:0] = result_ff[abr_pkg::LOW_BYTE_HI:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      dataOut <= '0;
      dataOutEn <= '0;
    end else begin
      dataOut <= nxt_dataOut;
      dataOutEn <= {abr_pkg::BUS_W{readActive}};
    end
  end
endmodule : abr_host_port

// file: bench/abr_host_port_asserts.sv
// Port checker for the converter byte-read host port.
// Assumes the host holds each strobe pattern for a whole read.
module abr_host_port_asserts (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire abr_pkg::abr_strobe_t strobeN,
  input wire logic [abr_pkg::BUS_W-1:0] dataOut,
  input wire logic [abr_pkg::BUS_W-1:0] dataOutEn,
  input wire logic busyN,
  input wire logic sampleNow
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic [8:0] lowCnt_ff;
  always_ff @(posedge core_clk) begin
    // Saturates so a long wait for a code cannot wrap into a short count
    lowCnt_ff <= (sys_rst || busyN) ? 9'h000 :
      lowCnt_ff + ((lowCnt_ff == 9'h1FF) ? 9'h000 : 9'h001);
  end
  chk_busy_sample: assert property ($fell(busyN) |-> sampleNow)
    else $error("busy fell without a sample pulse");
  chk_start_gate: assert property (sampleNow |-> !$past(strobeN.chipSelN, 3)
    && !$past(strobeN.readN, 3) && !$past(strobeN.highByteSelect, 3))
    else $error("conversion started without all three inputs low");
  chk_busy_length: assert property ($rose(busyN) |-> lowCnt_ff >= abr_pkg::CONV_CYCLES)
    else $error("busy low shorter than a conversion");
  chk_no_restart: assert property (!busyN && !$past(busyN) |-> !sampleNow)
    else $error("start accepted during a conversion");
  chk_output_float: assert property (dataOutEn != 12'h000 |->
    !$past(strobeN.chipSelN, 3) && !$past(strobeN.readN, 3))
    else $error("data lines driven without a read");
  chk_enable_uniform: assert property (dataOutEn == 12'h000 || dataOutEn == 12'hFFF)
    else $error("data line enables differ");
  chk_high_nibble: assert property (dataOutEn[0] && $past(strobeN.highByteSelect, 3)
    |-> dataOut[7:0] == {4'h0, dataOut[11:8]})
    else $error("high byte read shows wrong low lines");
  chk_sample_pulse: assert property (sampleNow |=> !sampleNow)
    else $error("sample pulse longer than one cycle");
endmodule : abr_host_port_asserts

// file: bench/abr_engine_model.sv
// Conversion engine stand-in: hands over one code per sample pulse.
// Burst holds valid high so the FIFO can be filled until it refuses.
module abr_engine_model (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic sampleNow,
  input wire logic burst,
  input wire logic convReady,
  output abr_pkg::abr_sample_t convCode,
  output logic convValid
);
  timeunit 1ns;
  timeprecision 1ns;
  logic pend_ff;
  assign convValid = burst || pend_ff;
  always_ff @(posedge core_clk) begin
    if (sys_rst) pend_ff <= 1'b0;
    else if (sampleNow) pend_ff <= 1'b1;
    else if (convReady) pend_ff <= 1'b0;
  end
  // Code steps on each accepted hand-over so order is visible
  always_ff @(posedge core_clk) begin
    if (sys_rst) convCode.code <= 12'hA5C;
    else if (convValid && convReady) convCode.code <= convCode.code + 12'h111;
  end
endmodule : abr_engine_model

// file: bench/testbench.sv
// Top bench for the converter byte-read host port.
// Assumes the engine model answers every sample pulse with the next code.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, sys_rst, busyN, sampleNow, convValid, convReady, burst;
  abr_pkg::abr_strobe_t strobeN;
  abr_pkg::abr_sample_t convCode;
  logic [11:0] dataOut, dataOutEn, res, newRes;
  int errors = 0;
  int samples_checked = 0;
  int i;
  abr_host_port abr_host_port_inst (.core_clk, .sys_rst, .strobeN, .dataOut, .dataOutEn,
    .busyN, .sampleNow, .convCode, .convValid, .convReady);
  abr_engine_model abr_engine_model_inst (.core_clk, .sys_rst, .sampleNow, .burst,
    .convReady, .convCode, .convValid);
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc
  task automatic set(input logic c, input logic r, input logic s);
    @(posedge core_clk);
    strobeN <= {c, r, s};
  endtask : set
  task automatic wait_busy_high;
    for (int k = 0; k < 1000; k++) begin
      if (busyN === 1'b1) return;
      cyc(1);
    end
    errors++;
    test_done();
  endtask : wait_busy_high
  // Slow memory byte pair: low read waits out busy, high read follows
  task automatic t_slow;
    set(1'b0, 1'b0, 1'b0);
    cyc(3);
    check({11'h000, sampleNow}, 12'h001);
    cyc(2);
    check({11'h000, busyN}, 12'h000);
    check(dataOut, res);
    wait_busy_high();
    res = newRes;
    newRes = newRes + 12'h111;
    cyc(2);
    check(dataOut, res);
    set(1'b1, 1'b1, 1'b0);
    cyc(4);
    check(dataOutEn, 12'h000);
    set(1'b0, 1'b0, 1'b1);
    cyc(5);
    check({11'h000, busyN}, 12'h001);
    check(dataOut, {res[11:8], 4'h0, res[11:8]});
    check(dataOutEn, 12'hFFF);
    set(1'b1, 1'b1, 1'b0);
    cyc(125);
    $display("slow byte read done");
  endtask : t_slow
  // ROM byte triple with a stray start during the conversion
  task automatic t_rom;
    set(1'b0, 1'b0, 1'b0);
    cyc(4);
    check(dataOut, res);
    set(1'b1, 1'b1, 1'b0);
    cyc(4);
    set(1'b0, 1'b0, 1'b0);
    cyc(4);
    set(1'b1, 1'b1, 1'b0);
    cyc(500);
    res = newRes;
    newRes = newRes + 12'h111;
    set(1'b0, 1'b0, 1'b1);
    cyc(5);
    check(dataOut, {res[11:8], 4'h0, res[11:8]});
    set(1'b1, 1'b1, 1'b1);
    cyc(4);
    set(1'b0, 1'b0, 1'b0);
    cyc(5);
    check(dataOut, res);
    check({11'h000, busyN}, 12'h000);
    set(1'b1, 1'b1, 1'b0);
    wait_busy_high();
    res = newRes;
    newRes = newRes + 12'h111;
    cyc(125);
    $display("rom byte read done");
  endtask : t_rom
  // Fill the FIFO until it refuses, then read the 32 filled codes out oldest first while each start refills it
  task automatic t_fifo;
    @(posedge core_clk);
    burst <= 1'b1;
    for (i = 0; i < 40; i++) begin
      cyc(1);
      if (convReady === 1'b0) break;
    end
    check(12'(i), 12'h01F);
    @(posedge core_clk);
    burst <= 1'b0;
    repeat (32) t_slow();
    $display("fifo fill and drain done");
  endtask : t_fifo
  initial begin
    sys_rst = 1'b1;
    strobeN = 3'b110;
    burst = 1'b0;
    res = 12'h000;
    newRes = 12'hA5C;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_slow();
    t_rom();
    t_fifo();
    test_done();
  end
endmodule : testbench
bind abr_host_port abr_host_port_asserts abr_host_port_asserts_inst (.core_clk, .sys_rst,
  .strobeN, .dataOut, .dataOutEn, .busyN, .sampleNow);
